// ---- rtl/efl_logger.sv ----
// Operation
// - Latch 64-bit data word of each interface's first single-bit error.
// - Latch the eight checkbits of each interface's first single-bit error.
// - Transaction info: tag in bits 5:0, chunk in 8:6, 15:9 zero.
// - Latch 64-bit data word of each interface's first double-bit error.
// - Latch checkbits of each interface's first double-bit error.
// - Captures are read-only, load only when their status bit sets.
// - 32-bit first-error status records the first detected error condition.
// - Writing one clears the bit in first and next status registers.
// - Bit 31 marks clear and error in one cycle, with another bit set.
// - Bit 30 flags a private data bus receive length error.
// - Bit 29 flags a ready strobe protocol error with busy signals.
// - Bit 28 flags a write data protocol error.
// - Next-error status, same layout, records errors after the first.
// - Bits 0 to 3: B single, B double, A single, A double.
`timescale 1ns/1ps
`default_nettype none

module efl_logger
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [63:0] I_CARD_B_ERROR_WORD,
    input wire logic [7:0] I_CARD_B_CHECKBITS,
    input wire logic [5:0] I_CARD_B_TRANSACTION_TAG,
    input wire logic [2:0] I_CARD_B_FAILING_CHUNK,
    input wire logic I_CARD_B_SINGLE_BIT_ERROR,
    input wire logic I_CARD_B_DOUBLE_BIT_ERROR,
    input wire logic [63:0] I_CARD_A_ERROR_WORD,
    input wire logic [7:0] I_CARD_A_CHECKBITS,
    input wire logic [5:0] I_CARD_A_TRANSACTION_TAG,
    input wire logic [2:0] I_CARD_A_FAILING_CHUNK,
    input wire logic I_CARD_A_SINGLE_BIT_ERROR,
    input wire logic I_CARD_A_DOUBLE_BIT_ERROR,
    input wire logic I_RECEIVE_LENGTH_ERROR,
    input wire logic I_READY_PROTOCOL_ERROR,
    input wire logic I_WRITE_PROTOCOL_ERROR,
    input wire logic [7:0] I_CFG_ADDR,
    input wire logic I_CFG_RD,
    input wire logic I_CFG_WR,
    input wire logic [3:0] I_CFG_BE,
    input wire logic [31:0] I_CFG_WDATA,
    output logic [31:0] O_CFG_RDATA,
    output logic O_CFG_RVALID
);

    typedef struct packed {
        logic [31:0] first_error_status;
        logic [31:0] next_error_status;
        logic [31:0] rdata;
        logic rvalid;
    } efl_state_type;

    efl_state_type state_q;
    efl_state_type state_d;

    logic [31:0] hw_events;
    logic [31:0] clear_mask;
    logic [31:0] first_after_clear;
    logic [31:0] read_word;
    logic [3:0] cap_load;
    logic [63:0] cap_data [4];
    logic [7:0] cap_ecc [4];
    logic [15:0] cap_txinfo [4];
    logic [63:0] src_data [4];
    logic [7:0] src_ecc [4];
    logic [5:0] src_tag [4];
    logic [2:0] src_chunk [4];

    // Byte enables widen to a bit mask
    function automatic logic [31:0] be_to_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    // One capture block as seen through a dword read
    function automatic logic [31:0] cap_dword(
        input logic [1:0] sel,
        input logic [63:0] data,
        input logic [7:0] ecc,
        input logic [15:0] txinfo
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (sel)
            efl_pkg::CAP_SEL_DATA_LOW: w = data[31:0];
            efl_pkg::CAP_SEL_DATA_HIGH: w = data[63:32];
            efl_pkg::CAP_SEL_ECC_TXINFO: w = {8'h00, txinfo, ecc};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Error event vector in status layout
    always_comb
    begin
        hw_events = 32'h0000_0000;
        hw_events[efl_pkg::BIT_CARD_B_SINGLE] = I_CARD_B_SINGLE_BIT_ERROR;
        hw_events[efl_pkg::BIT_CARD_B_DOUBLE] = I_CARD_B_DOUBLE_BIT_ERROR;
        hw_events[efl_pkg::BIT_CARD_A_SINGLE] = I_CARD_A_SINGLE_BIT_ERROR;
        hw_events[efl_pkg::BIT_CARD_A_DOUBLE] = I_CARD_A_DOUBLE_BIT_ERROR;
        hw_events[efl_pkg::BIT_RECEIVE_LENGTH] = I_RECEIVE_LENGTH_ERROR;
        hw_events[efl_pkg::BIT_READY_PROTOCOL] = I_READY_PROTOCOL_ERROR;
        hw_events[efl_pkg::BIT_WRITE_PROTOCOL] = I_WRITE_PROTOCOL_ERROR;
    end

    // Write-one-to-clear hits both status registers at either offset
    always_comb
    begin
        clear_mask = 32'h0000_0000;
        if (I_CFG_WR &&
            (I_CFG_ADDR == efl_pkg::OFS_FIRST_ERROR_STATUS ||
             I_CFG_ADDR == efl_pkg::OFS_NEXT_ERROR_STATUS))
        begin
            clear_mask = I_CFG_WDATA & be_to_mask(I_CFG_BE);
        end
    end

    assign first_after_clear = state_q.first_error_status & ~clear_mask;

    // Read decode
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (I_CFG_ADDR[7:6] == efl_pkg::CAP_BLOCK_HIGH)
        begin
            read_word = cap_dword(I_CFG_ADDR[3:2],
                                  cap_data[I_CFG_ADDR[5:4]],
                                  cap_ecc[I_CFG_ADDR[5:4]],
                                  cap_txinfo[I_CFG_ADDR[5:4]]);
        end
        else if (I_CFG_ADDR == efl_pkg::OFS_FIRST_ERROR_STATUS)
        begin
            read_word = state_q.first_error_status;
        end
        else if (I_CFG_ADDR == efl_pkg::OFS_NEXT_ERROR_STATUS)
        begin
            read_word = state_q.next_error_status;
        end
    end

    always_comb
    begin
        state_d = state_q;
        state_d.rvalid = I_CFG_RD;
        if (I_CFG_RD)
        begin
            state_d.rdata = read_word;
        end

        // First error only when no error is already held
        state_d.first_error_status = first_after_clear;
        state_d.next_error_status =
            state_q.next_error_status & ~clear_mask;
        if (state_q.first_error_status == efl_pkg::RST_STATUS)
        begin
            state_d.first_error_status =
                first_after_clear | hw_events;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            state_d.next_error_status =
                state_d.next_error_status | hw_events;
        end

        // Stale capture marker needs another bit still set
        if (|clear_mask && |hw_events &&
            |state_d.first_error_status[30:0])
        begin
            state_d.first_error_status[efl_pkg::BIT_STALE_CAPTURE] =
                1'b1;
        end
    end

    // Capture strobes on the rising edge of a first-error bit
    assign cap_load = ~state_q.first_error_status[3:0] &
                      state_d.first_error_status[3:0];

    // Classes 0,1 come from card B, 2,3 from card A
    assign src_data[0] = I_CARD_B_ERROR_WORD;
    assign src_data[1] = I_CARD_B_ERROR_WORD;
    assign src_data[2] = I_CARD_A_ERROR_WORD;
    assign src_data[3] = I_CARD_A_ERROR_WORD;
    assign src_ecc[0] = I_CARD_B_CHECKBITS;
    assign src_ecc[1] = I_CARD_B_CHECKBITS;
    assign src_ecc[2] = I_CARD_A_CHECKBITS;
    assign src_ecc[3] = I_CARD_A_CHECKBITS;
    assign src_tag[0] = I_CARD_B_TRANSACTION_TAG;
    assign src_tag[1] = I_CARD_B_TRANSACTION_TAG;
    assign src_tag[2] = I_CARD_A_TRANSACTION_TAG;
    assign src_tag[3] = I_CARD_A_TRANSACTION_TAG;
    assign src_chunk[0] = I_CARD_B_FAILING_CHUNK;
    assign src_chunk[1] = I_CARD_B_FAILING_CHUNK;
    assign src_chunk[2] = I_CARD_A_FAILING_CHUNK;
    assign src_chunk[3] = I_CARD_A_FAILING_CHUNK;

    for (genvar g = 0; g < efl_pkg::NUM_CLASSES; g++)
    begin : g_cap
        efl_capture u_cap
        (
            .i_clk(I_CORE_CLK),
            .i_rst_n(I_RST_N),
            .i_load(cap_load[g]),
            .i_data(src_data[g]),
            .i_ecc(src_ecc[g]),
            .i_tag(src_tag[g]),
            .i_chunk(src_chunk[g]),
            .o_data(cap_data[g]),
            .o_ecc(cap_ecc[g]),
            .o_txinfo(cap_txinfo[g])
        );
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state_q.first_error_status <= efl_pkg::RST_STATUS;
            state_q.next_error_status <= efl_pkg::RST_STATUS;
            state_q.rdata <= efl_pkg::RST_RDATA;
            state_q.rvalid <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Captures have no write path; writes there are ignored
    assign O_CFG_RDATA = state_q.rdata;
    assign O_CFG_RVALID = state_q.rvalid;

endmodule

`default_nettype wire

// ---- common/efl_pkg.sv ----
`default_nettype none

package efl_pkg;

    // Configuration space byte offsets
    localparam logic [7:0] OFS_CARD_B_SINGLE_BIT_DATA = 8'h40;
    localparam logic [7:0] OFS_CARD_B_SINGLE_BIT_CHECKBITS = 8'h48;
    localparam logic [7:0] OFS_CARD_B_SINGLE_BIT_TXINFO = 8'h49;
    localparam logic [7:0] OFS_CARD_B_DOUBLE_BIT_DATA = 8'h50;
    localparam logic [7:0] OFS_CARD_B_DOUBLE_BIT_CHECKBITS = 8'h58;
    localparam logic [7:0] OFS_CARD_B_DOUBLE_BIT_TXINFO = 8'h59;
    localparam logic [7:0] OFS_CARD_A_SINGLE_BIT_DATA = 8'h60;
    localparam logic [7:0] OFS_CARD_A_SINGLE_BIT_CHECKBITS = 8'h68;
    localparam logic [7:0] OFS_CARD_A_SINGLE_BIT_TXINFO = 8'h69;
    localparam logic [7:0] OFS_CARD_A_DOUBLE_BIT_DATA = 8'h70;
    localparam logic [7:0] OFS_CARD_A_DOUBLE_BIT_CHECKBITS = 8'h78;
    localparam logic [7:0] OFS_CARD_A_DOUBLE_BIT_TXINFO = 8'h79;
    localparam logic [7:0] OFS_FIRST_ERROR_STATUS = 8'h80;
    localparam logic [7:0] OFS_NEXT_ERROR_STATUS = 8'h84;

    // Capture block layout: class index is offset[5:4] above 0x40
    localparam logic [1:0] CAP_BLOCK_HIGH = 2'h1;
    localparam logic [1:0] CAP_SEL_DATA_LOW = 2'h0;
    localparam logic [1:0] CAP_SEL_DATA_HIGH = 2'h1;
    localparam logic [1:0] CAP_SEL_ECC_TXINFO = 2'h2;

    // Widths
    localparam int DATA_W = 64;
    localparam int ECC_W = 8;
    localparam int TAG_W = 6;
    localparam int CHUNK_W = 3;
    localparam int TXINFO_W = 16;
    localparam int STATUS_W = 32;
    localparam int NUM_CLASSES = 4;

    // Transaction info field positions
    localparam int TXINFO_TAG_LSB = 0;
    localparam int TXINFO_CHUNK_LSB = 6;
    localparam int TXINFO_RSVD_LSB = 9;

    // Status bit positions
    localparam int BIT_CARD_B_SINGLE = 0;
    localparam int BIT_CARD_B_DOUBLE = 1;
    localparam int BIT_CARD_A_SINGLE = 2;
    localparam int BIT_CARD_A_DOUBLE = 3;
    localparam int BIT_WRITE_PROTOCOL = 28;
    localparam int BIT_READY_PROTOCOL = 29;
    localparam int BIT_RECEIVE_LENGTH = 30;
    localparam int BIT_STALE_CAPTURE = 31;

    // Reset values
    localparam logic [63:0] RST_DATA = 64'h0000_0000_0000_0000;
    localparam logic [7:0] RST_ECC = 8'h00;
    localparam logic [15:0] RST_TXINFO = 16'h0000;
    localparam logic [31:0] RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // Bits hardware can set in the status registers
    localparam logic [31:0] STATUS_IMPL_MASK = 32'hF000_000F;

endpackage

`default_nettype wire

// ---- rtl/efl_capture.sv ----
`timescale 1ns/1ps
`default_nettype none

module efl_capture
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [63:0] i_data,
    input wire logic [7:0] i_ecc,
    input wire logic [5:0] i_tag,
    input wire logic [2:0] i_chunk,
    output logic [63:0] o_data,
    output logic [7:0] o_ecc,
    output logic [15:0] o_txinfo
);

    typedef struct packed {
        logic [63:0] data;
        logic [7:0] ecc;
        logic [5:0] tag;
        logic [2:0] chunk;
    } efl_cap_state_type;

    efl_cap_state_type state_q;
    efl_cap_state_type state_d;

    always_comb
    begin
        state_d = state_q;
        // Loads only on the rising edge of its status bit, else holds
        if (i_load)
        begin
            state_d.data = i_data;
            state_d.ecc = i_ecc;
            state_d.tag = i_tag;
            state_d.chunk = i_chunk;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q.data <= efl_pkg::RST_DATA;
            state_q.ecc <= efl_pkg::RST_ECC;
            state_q.tag <= efl_pkg::RST_TXINFO[5:0];
            state_q.chunk <= efl_pkg::RST_TXINFO[8:6];
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_data = state_q.data;
    assign o_ecc = state_q.ecc;
    // Upper bits tie low
    assign o_txinfo = {7'h00, state_q.chunk, state_q.tag};

endmodule

`default_nettype wire

// ---- dv/efl_logger_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module efl_logger_props
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_CFG_ADDR,
    input wire logic I_CFG_RD,
    input wire logic [31:0] O_CFG_RDATA,
    input wire logic O_CFG_RVALID
);
    // Holes include the gaps after each capture block
    wire logic rd_hole = I_CFG_RD && (I_CFG_ADDR < 8'h40
        || I_CFG_ADDR >= 8'h88 || I_CFG_ADDR[3:0] == 4'hC);
    wire logic rd_tx = I_CFG_RD && I_CFG_ADDR[7:6] == 2'h1
        && I_CFG_ADDR[3:0] == 4'h8;
    wire logic rd_st = I_CFG_RD && I_CFG_ADDR == 8'h80;
    wire logic rd_nx = I_CFG_RD && I_CFG_ADDR == 8'h84;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);
    a_read_answered: assert property (I_CFG_RD |=> O_CFG_RVALID)
        else $error("read not answered");
    a_no_stray_valid: assert property (!I_CFG_RD |=> !O_CFG_RVALID)
        else $error("valid without read");
    a_rdata_holds: assert property (
        !O_CFG_RVALID |-> $stable(O_CFG_RDATA))
        else $error("read data moved");
    a_hole_zero: assert property (rd_hole |=> O_CFG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    a_txinfo_rsvd: assert property (
        rd_tx |=> O_CFG_RDATA[31:17] == 15'h0)
        else $error("txinfo reserved bits set");
    a_first_gaps: assert property (
        rd_st |=> O_CFG_RDATA[27:4] == 24'h0)
        else $error("first status gap bits set");
    a_next_gaps: assert property (
        rd_nx |=> O_CFG_RDATA[27:4] == 24'h0)
        else $error("next status gap bits set");
    a_stale_alone: assert property (
        rd_st |=> !O_CFG_RDATA[31] || (|O_CFG_RDATA[30:0]))
        else $error("stale flag set alone");
endmodule

bind efl_logger efl_logger_props efl_logger_props_inst
(
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CFG_ADDR(I_CFG_ADDR),
    .I_CFG_RD(I_CFG_RD), .O_CFG_RDATA(O_CFG_RDATA),
    .O_CFG_RVALID(O_CFG_RVALID)
);

`default_nettype wire

// ---- dv/efl_err_src.sv ----
`timescale 1ns/1ps
`default_nettype none

module efl_err_src
(
    input wire logic i_clk,
    output logic [6:0] o_ev,
    output logic [63:0] o_word,
    output logic [7:0] o_ecc,
    output logic [5:0] o_tag,
    output logic [2:0] o_chunk
);
    initial {o_ev, o_word, o_ecc, o_tag, o_chunk} = '0;
    // Fields flip after the pulse so a late sample shows wrong data
    task automatic fire(input logic [6:0] ev, input logic [63:0] w,
        input logic [7:0] e, input logic [5:0] t, input logic [2:0] c);
        @(posedge i_clk);
        o_ev <= ev;
        {o_word, o_ecc, o_tag, o_chunk} <= {w, e, t, c};
        @(posedge i_clk);
        o_ev <= 7'h00;
        {o_word, o_ecc, o_tag, o_chunk} <= ~{w, e, t, c};
    endtask
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [63:0] W1 = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] W2 = 64'hFEDC_BA98_7654_3210;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0, rdata;
    logic rvalid;
    logic [6:0] ev;
    logic [63:0] w;
    logic [7:0] e;
    logic [5:0] t;
    logic [2:0] c;
    int n_mismatch = 0, cmp_count = 0;
    always #12.5 clk = ~clk;
    efl_err_src efl_err_src_inst
    (
        .i_clk(clk), .o_ev(ev), .o_word(w), .o_ecc(e), .o_tag(t),
        .o_chunk(c)
    );
    // Card A sees inverted fields so a swapped card shows up
    efl_logger efl_logger_inst
    (
        .I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_CARD_B_ERROR_WORD(w), .I_CARD_B_CHECKBITS(e),
        .I_CARD_B_TRANSACTION_TAG(t), .I_CARD_B_FAILING_CHUNK(c),
        .I_CARD_B_SINGLE_BIT_ERROR(ev[0]), .I_CARD_B_DOUBLE_BIT_ERROR(ev[1]),
        .I_CARD_A_ERROR_WORD(~w), .I_CARD_A_CHECKBITS(~e),
        .I_CARD_A_TRANSACTION_TAG(~t), .I_CARD_A_FAILING_CHUNK(~c),
        .I_CARD_A_SINGLE_BIT_ERROR(ev[2]), .I_CARD_A_DOUBLE_BIT_ERROR(ev[3]),
        .I_RECEIVE_LENGTH_ERROR(ev[4]), .I_READY_PROTOCOL_ERROR(ev[5]),
        .I_WRITE_PROTOCOL_ERROR(ev[6]), .I_CFG_ADDR(addr), .I_CFG_RD(rd),
        .I_CFG_WR(wr), .I_CFG_BE(be), .I_CFG_WDATA(wd),
        .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid)
    );
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
        chk("rvalid", 32'h0000_0001, {31'h0, rvalid});
    endtask
    // Byte enables default to a full dword write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] m = 4'hF);
        @(posedge clk);
        addr <= a;
        wr <= 1'b1;
        be <= m;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic cap_chk(input int k, input logic [63:0] dw,
        input logic [7:0] de, input logic [5:0] dt, input logic [2:0] dc);
        logic [7:0] b;
        b = 8'h40 + 8'(k * 16);
        if (k > 1)
            {dw, de, dt, dc} = ~{dw, de, dt, dc};
        rd_reg(b, dw[31:0]);
        rd_reg(b + 8'h04, dw[63:32]);
        rd_reg(b + 8'h08, {15'h0000, dc, dt, de});
    endtask
    task automatic t_reset;
        for (int a = 8'h40; a <= 8'h8C; a += 4)
            rd_reg(8'(a), 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_capture;
        efl_err_src_inst.fire(7'h0F, W1, 8'hA5, 6'h2A, 3'h5);
        rd_reg(8'h80, 32'h0000_000F);
        for (int k = 0; k < 4; k++)
            cap_chk(k, W1, 8'hA5, 6'h2A, 3'h5);
        $display("t_capture done");
    endtask
    task automatic t_hold;
        efl_err_src_inst.fire(7'h0F, W2, 8'h3C, 6'h15, 3'h2);
        rd_reg(8'h80, 32'h0000_000F);
        rd_reg(8'h84, 32'h0000_000F);
        for (int k = 0; k < 4; k++)
            cap_chk(k, W1, 8'hA5, 6'h2A, 3'h5);
        $display("t_hold done");
    endtask
    task automatic t_reload;
        wr_reg(8'h80, 32'h0000_0004);
        rd_reg(8'h80, 32'h0000_000B);
        rd_reg(8'h84, 32'h0000_000B);
        wr_reg(8'h80, 32'hFFFF_FFFF);
        rd_reg(8'h84, 32'h0000_0000);
        efl_err_src_inst.fire(7'h04, W2, 8'h3C, 6'h3F, 3'h7);
        rd_reg(8'h80, 32'h0000_0004);
        cap_chk(2, W2, 8'h3C, 6'h3F, 3'h7);
        cap_chk(0, W1, 8'hA5, 6'h2A, 3'h5);
        $display("t_reload done");
    endtask
    task automatic t_proto;
        wr_reg(8'h80, 32'hFFFF_FFFF);
        efl_err_src_inst.fire(7'h70, W1, 8'hA5, 6'h2A, 3'h5);
        rd_reg(8'h80, 32'h7000_0000);
        $display("t_proto done");
    endtask
    task automatic t_stale;
        wr_reg(8'h80, 32'hFFFF_FFFF);
        efl_err_src_inst.fire(7'h03, W1, 8'hA5, 6'h2A, 3'h5);
        fork
            wr_reg(8'h80, 32'h0000_0001);
            efl_err_src_inst.fire(7'h40, W2, 8'h3C, 6'h15, 3'h2);
        join
        rd_reg(8'h80, 32'h8000_0002);
        rd_reg(8'h84, 32'h1000_0000);
        // Only the top byte is enabled, so bit 1 must survive
        wr_reg(8'h80, 32'hFFFF_FFFF, 4'h8);
        rd_reg(8'h80, 32'h0000_0002);
        rd_reg(8'h84, 32'h0000_0000);
        $display("t_stale done");
    endtask
    // Reset in mid-run must wipe loaded captures and status
    task automatic t_midreset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h40; a <= 8'h8C; a += 4)
            rd_reg(8'(a), 32'h0);
        $display("t_midreset done");
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_capture;
        t_hold;
        t_reload;
        t_proto;
        t_stale;
        t_midreset;
        print_verdict;
    end
    // Run needs about two hundred cycles; fifteen times that is a hang
    initial
    begin
        #(25 * 3000);
        n_mismatch++;
        print_verdict;
    end
endmodule

`default_nettype wire
